// ---- logic/lbim_params.svh ----
`ifndef LBIM_PARAMS_SVH
`define LBIM_PARAMS_SVH

// Register offsets (byte addresses)
`define LBIM_OFF_STATUS    12'h500
`define LBIM_OFF_MASK      12'h504
`define LBIM_OFF_ENABLE    12'h508
`define LBIM_OFF_OUTBOX    12'h600

// Reset values
`define LBIM_RST_STATUS    32'h0000_0000
`define LBIM_RST_MASK      32'h0000_0000
`define LBIM_RST_ENABLE    32'h0000_0000
`define LBIM_RST_OUTBOX    32'h0000_0000

// Field positions
`define LBIM_SRC_BITS      19
`define LBIM_BIT_TRUNC     8
`define LBIM_BIT_STARVE    9
`define LBIM_BIT_TIMEOUT   10
`define LBIM_BIT_PROTO     11
`define LBIM_BIT_MBX_WR    12
`define LBIM_BIT_MBX_RD    13
`define LBIM_BIT_PIO_RD    14
`define LBIM_BIT_PIO_WR    15
`define LBIM_BIT_TXDMA     16
`define LBIM_BIT_RXDMA     17
`define LBIM_BIT_EXTIRQ    18
`define LBIM_MBOX_BITS     16
`define LBIM_CFG_MBX_IRQ   2

// Local bus address of the outbound mailbox
`define LBIM_LB_ADDR_OUTBOX 15'h0008

`endif

// ---- logic/lbim_pkg.sv ----
package lbim_pkg;

   // CPU register access
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } lbim_cpu_req_t;

   // Event strobes from the local bus logic
   typedef struct packed {
      logic trunc;
      logic starve;
      logic timeout;
      logic proto;
      logic mbx_wr;
      logic pio_rd_to;
      logic pio_wr_to;
      logic txdma_to;
      logic rxdma_to;
      logic ext_irq;
   } lbim_events_t;

   // Local bus master read strobe
   typedef struct packed {
      logic        rd;
      logic [14:0] addr;
   } lbim_lb_rd_t;

   // Outbound mailbox handshake states
   typedef enum logic [0:0] {
      LBIM_MBX_IDLE    = 1'b0,
      LBIM_MBX_PENDING = 1'b1
   } lbim_mbx_state_t;

endpackage

// ---- logic/lbim_reg_bank.sv ----
`timescale 1ns/10ps
`include "lbim_params.svh"

module lbim_reg_bank #(
   parameter int WIDTH = 32
) (
   input  wire logic             core_clk_i,   // System clock
   input  wire logic             reset_i,      // Async reset, high
   input  wire logic             wr_en_i,      // Write strobe
   input  wire logic [WIDTH-1:0] wr_mask_i,    // Writable bits
   input  wire logic [WIDTH-1:0] wr_data_i,    // Write data
   output logic      [WIDTH-1:0] q_o           // Stored value
);

   logic [WIDTH-1:0] next_q;

   ////////////////////////////////////////////////////////////////////////
   // Masked write of the stored word
   always_comb
   begin
      next_q = q_o;
      if (wr_en_i)
      begin
         next_q = (q_o & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         q_o <= '0;
      end
      else
      begin
         q_o <= next_q;
      end
   end

endmodule

// ---- logic/lbim_top.sv ----
`timescale 1ns/10ps
`include "lbim_params.svh"

module lbim_top
   import lbim_pkg::*;
(
   input  wire logic                 core_clk_i,  // 200 MHz clock
   input  wire logic                 reset_i,     // Async reset, high
   input  lbim_pkg::lbim_cpu_req_t   cpu_req_i,   // CPU register access
   output logic      [31:0]          cpu_rdata_o, // CPU read data
   input  wire logic [31:0]          misc_cfg_i,  // Misc config word
   input  wire logic                 host_mode_i, // Device in host mode
   input  lbim_pkg::lbim_events_t    events_i,    // Event strobes
   input  lbim_pkg::lbim_lb_rd_t     lb_rd_i,     // Master read strobe
   output logic      [15:0]          lb_mbox_o,   // Mailbox to master
   output logic                      host_irq_line_o, // Line to master
   output logic                      irq_o,       // Block interrupt
   output logic      [18:0]          status_o     // Status snapshot
);
   import lbim_pkg::*;

   localparam int NSRC = `LBIM_SRC_BITS;
   localparam int MBW  = `LBIM_MBOX_BITS;

   // Writable bits of the stored registers
   localparam logic [31:0] MASK_WBITS   = 32'h0007_ffff;
   localparam logic [31:0] ENABLE_WBITS = 32'h0000_0001;
   localparam logic [31:0] OUTBOX_WBITS = 32'h0000_ffff;

   logic [NSRC-1:0] status;
   logic [NSRC-1:0] next_status;
   logic [NSRC-1:0] set_vec;
   logic [NSRC-1:0] clr_vec;
   logic [31:0]     mask_q;
   logic [31:0]     enable_q;
   logic [31:0]     outbox_q;
   logic            wr_mask;
   logic            wr_enable;
   logic            wr_outbox;
   logic            wr_status;
   logic            lb_outbox_rd;
   lbim_mbx_state_t mbx_state;
   lbim_mbx_state_t next_mbx_state;
   logic [31:0]     next_rdata;
   logic            next_irq;
   logic [NSRC-1:0] masked_vec;
   logic            next_line;
   logic [MBW-1:0]  next_mbox;

   ////////////////////////////////////////////////////////////////////////
   // Address decode of CPU writes
   always_comb
   begin
      wr_status = 1'b0;
      wr_mask   = 1'b0;
      wr_enable = 1'b0;
      wr_outbox = 1'b0;
      if (cpu_req_i.wr)
      begin
         unique case (cpu_req_i.addr)
            `LBIM_OFF_STATUS: wr_status = 1'b1;
            `LBIM_OFF_MASK:   wr_mask   = 1'b1;
            `LBIM_OFF_ENABLE: wr_enable = 1'b1;
            `LBIM_OFF_OUTBOX: wr_outbox = 1'b1;
            default:          wr_status = 1'b0;
         endcase
      end
   end

   // Master read of the outbound mailbox
   assign lb_outbox_rd = lb_rd_i.rd &&
                         lb_rd_i.addr == `LBIM_LB_ADDR_OUTBOX;

   ////////////////////////////////////////////////////////////////////////
   // Mask, enable and mailbox storage
   // mask bits 18:0
   lbim_reg_bank #(.WIDTH(32)) u_mask (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .wr_en_i    (wr_mask),
      .wr_mask_i  (MASK_WBITS),
      .wr_data_i  (cpu_req_i.wdata),
      .q_o        (mask_q)
   );

   lbim_reg_bank #(.WIDTH(32)) u_enable (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .wr_en_i    (wr_enable),
      .wr_mask_i  (ENABLE_WBITS),
      .wr_data_i  (cpu_req_i.wdata),
      .q_o        (enable_q)
   );

   lbim_reg_bank #(.WIDTH(32)) u_outbox (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .wr_en_i    (wr_outbox),
      .wr_mask_i  (OUTBOX_WBITS),
      .wr_data_i  (cpu_req_i.wdata),
      .q_o        (outbox_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Event sources onto status positions
   always_comb
   begin
      set_vec = '0;
      set_vec[`LBIM_BIT_TRUNC]   = events_i.trunc;
      set_vec[`LBIM_BIT_STARVE]  = events_i.starve;
      set_vec[`LBIM_BIT_TIMEOUT] = events_i.timeout;
      set_vec[`LBIM_BIT_PROTO]   = events_i.proto;
      set_vec[`LBIM_BIT_MBX_WR]  = events_i.mbx_wr;
      set_vec[`LBIM_BIT_MBX_RD]  = lb_outbox_rd;
      set_vec[`LBIM_BIT_PIO_RD]  = host_mode_i && events_i.pio_rd_to;
      set_vec[`LBIM_BIT_PIO_WR]  = host_mode_i && events_i.pio_wr_to;
      set_vec[`LBIM_BIT_TXDMA]   = host_mode_i && events_i.txdma_to;
      set_vec[`LBIM_BIT_RXDMA]   = host_mode_i && events_i.rxdma_to;
      set_vec[`LBIM_BIT_EXTIRQ]  = host_mode_i && events_i.ext_irq;
   end

   assign clr_vec = wr_status ? cpu_req_i.wdata[NSRC-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////
   // Status bits, set wins over clear
   // mask not involved here
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++)
      begin : g_stat
         assign next_status[gi] = set_vec[gi] |
                                  (status[gi] & ~clr_vec[gi]);
      end
   endgenerate

   // Status register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         status <= '0;
      end
      else
      begin
         status <= next_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outbound mailbox line to master
   always_comb
   begin
      next_mbx_state = mbx_state;
      unique case (mbx_state)
         LBIM_MBX_IDLE:
         begin
            if (wr_outbox && misc_cfg_i[`LBIM_CFG_MBX_IRQ])
            begin
               next_mbx_state = LBIM_MBX_PENDING;
            end
         end
         LBIM_MBX_PENDING:
         begin
            if (lb_outbox_rd && !wr_outbox)
            begin
               next_mbx_state = LBIM_MBX_IDLE;
            end
         end
      endcase
   end

   // Handshake state register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mbx_state <= LBIM_MBX_IDLE;
      end
      else
      begin
         mbx_state <= next_mbx_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-bit gating of status by mask
   // one mask bit per source
   generate
      for (gi = 0; gi < NSRC; gi++)
      begin : g_mask
         assign masked_vec[gi] = status[gi] & mask_q[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read mux for the CPU
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (cpu_req_i.rd)
      begin
         unique case (cpu_req_i.addr)
            `LBIM_OFF_STATUS: next_rdata = {13'h0000, status};
            `LBIM_OFF_MASK:   next_rdata = mask_q;
            `LBIM_OFF_ENABLE: next_rdata = enable_q;
            `LBIM_OFF_OUTBOX: next_rdata = outbox_q;
            default:          next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cpu_rdata_o <= 32'h0000_0000;
      end
      else
      begin
         cpu_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt, line and mailbox outputs
   always_comb
   begin
      next_irq  = enable_q[0] && (|masked_vec);
      next_line = next_mbx_state == LBIM_MBX_PENDING;
      // mailbox data after this cycle's write
      next_mbox = next_outbox_data(outbox_q, wr_outbox, cpu_req_i.wdata);
   end

   // Output registers toward the master and the CPU
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_o           <= 1'b0;
         host_irq_line_o <= 1'b0;
         lb_mbox_o       <= 16'h0000;
         status_o        <= '0;
      end
      else
      begin
         irq_o           <= next_irq;
         host_irq_line_o <= next_line;
         lb_mbox_o       <= next_mbox;
         status_o        <= next_status;
      end
   end

   // Mailbox data as seen after this cycle's write
   function automatic logic [MBW-1:0] next_outbox_data(
      input logic [31:0] cur,
      input logic        we,
      input logic [31:0] wd
   );
      next_outbox_data = we ? wd[MBW-1:0] : cur[MBW-1:0];
   endfunction

endmodule

// ---- test/lbim_checker_assertions.sv ----
`timescale 1ns/10ps
module lbim_checker
   import lbim_pkg::*;
(
   input  wire logic             core_clk_i,      // Clock
   input  wire logic             reset_i,         // Reset
   input  lbim_pkg::lbim_cpu_req_t cpu_req_i,     // CPU access
   input  wire logic [31:0]      cpu_rdata_o,     // Read data
   input  wire logic [31:0]      misc_cfg_i,      // Config word
   input  wire logic             host_mode_i,     // Host mode
   input  lbim_pkg::lbim_events_t events_i,       // Event strobes
   input  lbim_pkg::lbim_lb_rd_t lb_rd_i,         // Master read
   input  wire logic [15:0]      lb_mbox_o,       // Mailbox out
   input  wire logic             host_irq_line_o, // Host line
   input  wire logic             irq_o,           // Interrupt
   input  wire logic [18:0]      status_o         // Status copy
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////
   // Mailbox access steps
   sequence s_mbx_wr; cpu_req_i.wr && cpu_req_i.addr == 12'h600; endsequence
   sequence s_mbx_rd; lb_rd_i.rd && lb_rd_i.addr == 15'h0008; endsequence
   property p_trunc; events_i.trunc |=> status_o[8]; endproperty
   property p_starve; events_i.starve |=> status_o[9]; endproperty
   property p_pio; host_mode_i && events_i.pio_wr_to |=> status_o[15];
   endproperty
   property p_nohost; !host_mode_i && !status_o[18] |=> !status_o[18];
   endproperty
   property p_quiet; status_o == 19'h0 |=> !irq_o; endproperty
   property p_line; s_mbx_wr ##0 misc_cfg_i[2] |=> host_irq_line_o;
   endproperty
   property p_clr;
      s_mbx_rd ##0 !cpu_req_i.wr |=> !host_irq_line_o ##0 status_o[13];
   endproperty
   property p_mbox;
      s_mbx_wr |=> lb_mbox_o == $past(cpu_req_i.wdata[15:0]);
   endproperty
   property p_idle; !cpu_req_i.rd |=> cpu_rdata_o == 32'h0; endproperty
   property p_resv; cpu_req_i.rd && cpu_req_i.addr == 12'h504
      |=> cpu_rdata_o[31:19] == 13'h0; endproperty
   ////////////////////////////////////////////////////////////////////////
   a_trunc: assert property (p_trunc)
      else $error("early restart not flagged");
   a_starve: assert property (p_starve)
      else $error("starvation not flagged");
   a_pio: assert property (p_pio)
      else $error("write timeout not flagged");
   a_nohost: assert property (p_nohost)
      else $error("host event taken in device mode");
   a_quiet: assert property (p_quiet)
      else $error("interrupt without status");
   a_line: assert property (p_line)
      else $error("host line not raised");
   a_clr: assert property (p_clr)
      else $error("master read did not clear line");
   a_mbox: assert property (p_mbox)
      else $error("mailbox data wrong");
   a_idle: assert property (p_idle)
      else $error("read data not idle");
   a_resv: assert property (p_resv)
      else $error("reserved mask bits set");
endmodule
bind lbim_top lbim_checker chk_u (.core_clk_i, .reset_i, .cpu_req_i,
   .cpu_rdata_o, .misc_cfg_i, .host_mode_i, .events_i, .lb_rd_i,
   .lb_mbox_o, .host_irq_line_o, .irq_o, .status_o);

// ---- test/lbim_lb_master.sv ----
`timescale 1ns/10ps
module lbim_lb_master
   import lbim_pkg::*;
(
   input  wire logic            core_clk_i, // Clock
   input  wire logic            go_i,       // Start a read
   input  wire logic [3:0]      wait_i,     // Delay in cycles
   output lbim_pkg::lbim_lb_rd_t lb_rd_o    // Read strobe
);
   logic [3:0]  cnt = 4'h0;
   logic        busy = 1'b0;
   logic [14:0] junk = 15'h0;
   lbim_lb_rd_t rd_q = '0;
   assign lb_rd_o = rd_q;
   always @(posedge core_clk_i)
   begin
      junk <= junk + 15'h1235;
      rd_q <= '{1'b0, junk};
      if (go_i)
      begin
         busy <= 1'b1;
         cnt <= wait_i;
      end
      else if (busy && cnt != 4'h0)
         cnt <= cnt - 4'h1;
      else if (busy)
      begin
         busy <= 1'b0;
         rd_q <= '{1'b1, 15'h0008};
      end
   end
endmodule

// ---- test/local_bus_irq_mailbox_bench.sv ----
`timescale 1ns/10ps
module local_bus_irq_mailbox_bench;
   import lbim_pkg::*;
   logic          core_clk_i = 1'b0;
   logic          reset_i = 1'b1;
   lbim_cpu_req_t cpu_req = '0;
   logic [31:0]   rdata;
   logic [31:0]   misc_cfg = 32'h0;
   logic          host_mode = 1'b0;
   lbim_events_t  events = '0;
   lbim_lb_rd_t   lb_rd;
   logic [15:0]   lb_mbox;
   logic          line;
   logic          irq;
   logic [18:0]   status;
   logic          go = 1'b0;
   logic [3:0]    wait_n = 4'h0;
   int            error_cnt = 0;
   int            checks_done = 0;
   // Clock and instances
   always #2.5 core_clk_i = ~core_clk_i;
   lbim_top dut_u (.core_clk_i, .reset_i, .cpu_req_i(cpu_req),
      .cpu_rdata_o(rdata), .misc_cfg_i(misc_cfg), .host_mode_i(host_mode),
      .events_i(events), .lb_rd_i(lb_rd), .lb_mbox_o(lb_mbox),
      .host_irq_line_o(line), .irq_o(irq), .status_o(status));
   lbim_lb_master lbm_u (.core_clk_i, .go_i(go), .wait_i(wait_n),
      .lb_rd_o(lb_rd));
   ////////////////////////////////////////////////////////////////////////
   // Compare and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i) cpu_req <= '{1'b0, 1'b1, a, d};
      @(posedge core_clk_i) cpu_req <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge core_clk_i) cpu_req <= '{1'b1, 1'b0, a, 32'h0};
      @(posedge core_clk_i) cpu_req <= '0;
      @(negedge core_clk_i) chk(rdata, e);
   endtask
   task automatic pulse(input lbim_events_t ev);
      @(posedge core_clk_i) events <= ev;
      @(posedge core_clk_i) events <= '0;
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(12'h500, 32'h0);
      rd(12'h504, 32'h0);
      rd(12'h508, 32'h0);
      rd(12'h600, 32'h0);
      wr(12'h700, 32'hffff_ffff);
      rd(12'h700, 32'h0);
      pulse('1);
      rd(12'h500, 32'h0000_1f00);
      wr(12'h508, 32'hffff_ffff);
      rd(12'h508, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(12'h504, 32'hffff_ffff);
      rd(12'h504, 32'h0007_ffff);
      chk({31'h0, irq}, 32'h1);
      wr(12'h508, 32'h0);
      rd(12'h508, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(12'h500, 32'h0000_0100);
      wr(12'h504, 32'h0);
      wr(12'h500, 32'h0);
      rd(12'h500, 32'h0000_1e00);
      wr(12'h500, 32'hffff_ffff);
      @(posedge core_clk_i) host_mode <= 1'b1;
      pulse('1);
      rd(12'h500, 32'h0007_df00);
      wr(12'h500, 32'hffff_ffff);
      // Alternating sources check each event bit position (bit 13 comes from the master read)
      pulse(10'h2aa);
      rd(12'h500, 32'h0002_9500);
      wr(12'h500, 32'hffff_ffff);
      pulse(10'h155);
      rd(12'h500, 32'h0005_4a00);
      wr(12'h500, 32'hffff_ffff);
      wr(12'h600, 32'habcd_5678);
      rd(12'h600, 32'h0000_5678);
      chk({16'h0, lb_mbox}, 32'h0000_5678);
      chk({31'h0, line}, 32'h0);
      @(posedge core_clk_i) misc_cfg <= 32'h0000_0004;
      // Prompt and slow master reads
      for (int k = 0; k < 2; k++)
      begin
         wr(12'h600, 32'h0000_1234);
         rd(12'h600, 32'h0000_1234);
         rd(12'h500, 32'h0);
         chk({31'h0, line}, 32'h1);
         @(posedge core_clk_i) go <= 1'b1;
         wait_n <= 4'(9 * k);
         @(posedge core_clk_i) go <= 1'b0;
         for (int i = 0; i < 20 && line !== 1'b0; i++)
            @(negedge core_clk_i);
         chk({31'h0, line}, 32'h0);
         rd(12'h500, 32'h0000_2000);
         wr(12'h500, 32'hffff_ffff);
      end
      // Warm reset in mid-run clears mailbox and line
      wr(12'h600, 32'h0000_00a5);
      @(posedge core_clk_i) reset_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(12'h600, 32'h0);
      chk({16'h0, lb_mbox}, 32'h0);
      chk({31'h0, line}, 32'h0);
      give_verdict;
   end
   // Watchdog
   initial
   begin
      #20000;
      error_cnt++;
      give_verdict;
   end
endmodule
